// [src/ptp_clock_pkg.sv]
/*
 * Shared constants and types for the synchronized time-of-day clock:
 * register offsets, control fields, reset values and fixed-point constants.
 * Assumes a single 20 MHz system clock; the nominal reference period is
 * modelled by ticks that stand for 8 ns of time each.
 */
`default_nettype none

package ptp_clock_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned SYS_CLK_HZ     = 20_000_000;
	localparam int unsigned REF_CLK_HZ     = 125_000_000;
	localparam int unsigned REF_PERIOD_NS  = 1_000_000_000 / REF_CLK_HZ;
	localparam int unsigned OUT_SRC_HZ     = 250_000_000;
	localparam int unsigned OUT_SRC_NS     = 1_000_000_000 / OUT_SRC_HZ;

	// ==========================================================
	// Fixed point (2^-32 ns units)
	localparam int unsigned        FRAC_W        = 32;
	localparam int unsigned        NS_W          = 30;
	localparam int unsigned        INC_W         = 48;
	localparam logic [29:0]        NS_PER_SEC    = 30'h3B9ACA00;
	localparam logic [29:0]        NS_MAX        = 30'h3B9AC9FF;
	localparam logic [63:0]        ONE_SEC_FRAC  = 64'h3B9ACA0000000000;
	localparam logic [INC_W-1:0]   NOMINAL_INC   = INC_W'(REF_PERIOD_NS) << FRAC_W;
	localparam logic [INC_W-1:0]   HALF_SRC_FRAC = INC_W'(OUT_SRC_NS / 2) << FRAC_W;

	// ==========================================================
	// Register map (byte addresses)
	localparam int unsigned ADDR_W       = 6;
	localparam logic [5:0]  OFF_CTRL     = 6'h00;
	localparam logic [5:0]  OFF_SEC      = 6'h04;
	localparam logic [5:0]  OFF_NS       = 6'h08;
	localparam logic [5:0]  OFF_FRAC     = 6'h0C;
	localparam logic [5:0]  OFF_STEP     = 6'h10;
	localparam logic [5:0]  OFF_RATE     = 6'h14;
	localparam logic [5:0]  OFF_TRATE    = 6'h18;
	localparam logic [5:0]  OFF_TDUR     = 6'h1C;
	localparam logic [5:0]  OFF_REF_DIV  = 6'h20;
	localparam logic [5:0]  OFF_OUT_DIV  = 6'h24;
	localparam logic [5:0]  OFF_STATUS   = 6'h28;

	// ==========================================================
	// Control fields and reset values
	localparam int unsigned CTRL_EN      = 0;
	localparam int unsigned CTRL_SRC_LO  = 1;
	localparam int unsigned CTRL_LOAD    = 3;
	localparam int unsigned CTRL_OUT_EN  = 4;
	localparam logic [7:0]  DIV_MIN      = 8'h02;
	localparam logic [7:0]  REF_DIV_RST  = 8'h02;
	localparam logic [7:0]  OUT_DIV_RST  = 8'h0A;
	localparam logic        EN_RST       = 1'b1;
	localparam logic        OUT_EN_RST   = 1'b0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {SRC_INTERNAL, SRC_DIVIDED, SRC_EXTERNAL} clk_src_t;

	typedef struct packed {
		logic [31:0]      sec;
		logic [NS_W-1:0]  ns;
		logic [FRAC_W-1:0] frac;
	} ptp_time_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

endpackage

`default_nettype wire

// [src/ref_tick_gen.sv]
/*
 * Reference tick source for the time clock: internal reference, divided
 * internal reference, or a rising edge on an external reference input.
 * Assumes ext_ref is synchronous to sys_clk and changes at most every
 * other cycle.
 */
`default_nettype none

module ref_tick_gen
	import ptp_clock_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Control
	input  wire logic       enable,
	input  wire clk_src_t   src,
	input  wire logic [7:0] ref_div,
	input  wire logic       ext_ref,
	// Tick out
	output var  logic       tick,
	output var  logic [7:0] scale
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       ext_prev;
		logic       tick;
		logic [7:0] scale;
	} tick_st_t;

	tick_st_t st_q;
	tick_st_t st_d;

	always_comb
	begin
		st_d          = st_q;
		st_d.ext_prev = ext_ref;
		st_d.tick     = 1'b0;
		st_d.scale    = 8'h01;
		case (src)
			SRC_INTERNAL:
				st_d.tick = enable;
			SRC_DIVIDED:
			begin
				// Fewer, larger steps: less toggling, coarser time
				st_d.scale = ref_div;
				if (st_q.cnt >= ref_div - 8'h01)
				begin
					st_d.cnt  = 8'h00;
					st_d.tick = enable;
				end
				else
					st_d.cnt = st_q.cnt + 8'h01;
			end
			SRC_EXTERNAL:
				st_d.tick = enable && ext_ref && !st_q.ext_prev;
			default:
				st_d.tick = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_q <= '{cnt: 8'h00, ext_prev: 1'b0, tick: 1'b0, scale: 8'h01};
		else if (ce)
			st_q <= st_d;
	end

	assign tick  = st_q.tick;
	assign scale = st_q.scale;

	a_ext_edge_tick: assert property (@(posedge sys_clk) disable iff (rst)
		ce && src == SRC_EXTERNAL && enable && ext_ref && !st_q.ext_prev |=> tick)
		else $error("external edge gave no tick");

	a_div_tick_scale: assert property (@(posedge sys_clk) disable iff (rst)
		ce && src == SRC_DIVIDED |=> scale == $past(ref_div))
		else $error("divided tick scale wrong");

endmodule

`default_nettype wire

// [src/sync_clock_out.sv]
/*
 * Synchronized clock output: a numerically controlled oscillator that
 * advances by the rate-adjusted time increment and toggles every
 * divisor times half the 4 ns source period.
 * Assumes increment and tick come from the time clock in the same domain.
 */
`default_nettype none

module sync_clock_out
	import ptp_clock_pkg::*;
#(
	parameter int unsigned MAX_EDGES = 4
)
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Control
	input  wire logic             out_en,
	input  wire logic             tick,
	input  wire logic [INC_W-1:0] inc,
	input  wire logic [7:0]       divisor,
	// Clock out
	output var  logic             clk_o
);

	// Elaboration guard: the edge loop is unrolled, so it must stay small
	if (MAX_EDGES < 1 || MAX_EDGES > 16)
	begin : g_bad_edges
		$error("MAX_EDGES out of range");
	end

	typedef struct packed {
		logic [INC_W-1:0] acc;
		logic             lvl;
	} nco_st_t;

	nco_st_t          st_q;
	nco_st_t          st_d;
	logic [INC_W-1:0] half;

	// Phase follows rate only; steps of the time value never reach it
	always_comb
	begin
		half = INC_W'(divisor) * HALF_SRC_FRAC;
		st_d = st_q;
		if (!out_en)
			st_d = '0;
		else if (tick)
		begin
			st_d.acc = st_q.acc + inc;
			for (int i = 0; i < MAX_EDGES; i++)
			begin
				if (st_d.acc >= half)
				begin
					st_d.acc = st_d.acc - half;
					st_d.lvl = !st_d.lvl;
				end
			end
			// Beyond MAX_EDGES toggles per tick the output cannot follow; drop excess phase
			if (st_d.acc >= half)
				st_d.acc = '0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else if (ce)
			st_q <= st_d;
	end

	assign clk_o = st_q.lvl;

endmodule

`default_nettype wire

// [src/ptp_time_clock.sv]
/*
 * Synchronized time-of-day clock with direct load, signed step, persistent
 * and temporary rate adjustment, selectable reference source and a
 * rate-following clock output, all reached over a plain register port.
 * Assumes one 20 MHz clock, strobes one cycle long and never together.
 */
// Strobed register access and the placing of the registers are this design's own decisions.
// Contract
// - Time is seconds, nanoseconds, 2^-32 ns fraction.
// - Software loads whole new time outright.
// - Signed nanosecond step adds to running time.
// - Persistent rate adjusts each tick in 2^-32 ns.
// - Temporary rate applies only for programmed duration.
// - Time is unsigned; no negative time kept.
// - Only 32 low seconds bits are kept.
// - Clock output is 250 MHz over 2..255.
// - Clock output follows current and temporary rate.
// - Clock output phase ignores time steps.
// - Time logic runs on nominal 125 MHz reference.
// - Divided reference source selectable for lower power.
// - External reference up to 125 MHz selectable.
`default_nettype none

module ptp_time_clock
	import ptp_clock_pkg::*;
(
	// Clock, reset, enable
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output var  logic [31:0]       rdata,
	// Reference and outputs
	input  wire logic              ext_ref,
	output var  ptp_time_t         time_now,
	output var  logic              temp_active,
	output var  logic              sync_clk_out
);

	// ==========================================================
	// State
	typedef struct packed {
		logic               enable;
		clk_src_t           src;
		logic               out_en;
		logic [7:0]         ref_div;
		logic [7:0]         out_div;
		logic [31:0]        sec_stage;
		logic [NS_W-1:0]    ns_stage;
		logic signed [31:0] rate;
		logic signed [31:0] temp_rate;
		logic [31:0]        dur;
		ptp_time_t          tm;
		logic [31:0]        rdata;
		logic               temp;
	} clock_st_t;

	clock_st_t          st_q;
	clock_st_t          st_d;
	reg_req_t           req;
	logic               tick;
	logic [7:0]         scale;
	logic               tick_eff;
	logic               temp_on;
	logic signed [31:0] act_rate;
	logic [INC_W-1:0]   inc_base;
	logic [INC_W-1:0]   inc;
	logic signed [65:0] acc;
	logic [31:0]        sec;
	logic               do_load;
	logic               do_step;

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	function automatic logic [7:0] clamp_div(input logic [31:0] v);
		if (v[31:8] != 24'h0)
			return 8'hFF;
		else if (v[7:0] < DIV_MIN)
			return DIV_MIN;
		else
			return v[7:0];
	endfunction

	function automatic clk_src_t decode_src(input logic [1:0] v);
		case (v)
			2'h1:    return SRC_DIVIDED;
			2'h2:    return SRC_EXTERNAL;
			default: return SRC_INTERNAL;
		endcase
	endfunction

	// ==========================================================
	// Reference ticks
	ref_tick_gen u_ticks (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.enable  (st_q.enable),
		.src     (st_q.src),
		.ref_div (st_q.ref_div),
		.ext_ref (ext_ref),
		.tick    (tick),
		.scale   (scale)
	);

	// ==========================================================
	// Increment
	always_comb
	begin
		temp_on  = st_q.dur != 32'h0;
		act_rate = temp_on ? st_q.temp_rate : st_q.rate;
		inc_base = NOMINAL_INC + INC_W'(act_rate);
		inc      = INC_W'(inc_base * INC_W'(scale));
		tick_eff = tick && st_q.enable;
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		st_d       = st_q;
		st_d.rdata = 32'h0;
		do_load    = req.wr && req.addr == OFF_CTRL && req.wdata[CTRL_LOAD];
		do_step    = req.wr && req.addr == OFF_STEP;

		// Temporary duration counts reference periods; a write restarts it
		if (tick_eff && temp_on)
			st_d.dur = (st_q.dur > 32'(scale)) ? st_q.dur - 32'(scale) : 32'h0;

		// Time: fraction and ns in one fixed-point word, seconds apart
		acc = {4'h0, st_q.tm.ns, st_q.tm.frac};
		sec = st_q.tm.sec;
		if (tick_eff)
			acc = acc + {18'h0, inc};
		if (do_step)
			acc = acc + {{2{req.wdata[31]}}, req.wdata, 32'h0};
		// A step of up to 2^31 ns spans at most three seconds
		for (int i = 0; i < 4; i++)
		begin
			if (acc < 0)
			begin
				acc = acc + $signed({2'b00, ONE_SEC_FRAC});
				sec = sec - 32'h1;
			end
			else if (acc >= $signed({2'b00, ONE_SEC_FRAC}))
			begin
				acc = acc - $signed({2'b00, ONE_SEC_FRAC});
				sec = sec + 32'h1;
			end
		end
		st_d.tm.sec  = sec;
		st_d.tm.ns   = acc[61:32];
		st_d.tm.frac = acc[31:0];

		if (do_load)
		begin
			st_d.tm.sec  = st_q.sec_stage;
			st_d.tm.ns   = st_q.ns_stage;
			st_d.tm.frac = 32'h0;
		end

		if (req.wr)
		begin
			case (req.addr)
				OFF_CTRL:
				begin
					st_d.enable = req.wdata[CTRL_EN];
					st_d.src    = decode_src(req.wdata[CTRL_SRC_LO +: 2]);
					st_d.out_en = req.wdata[CTRL_OUT_EN];
				end
				OFF_SEC:     st_d.sec_stage = req.wdata;
				OFF_NS:      st_d.ns_stage  = (req.wdata[29:0] > NS_MAX || req.wdata[31:30] != 2'h0)
					? NS_MAX : req.wdata[29:0];
				OFF_RATE:    st_d.rate      = req.wdata;
				OFF_TRATE:   st_d.temp_rate = req.wdata;
				OFF_TDUR:    st_d.dur       = req.wdata;
				OFF_REF_DIV: st_d.ref_div   = clamp_div(req.wdata);
				OFF_OUT_DIV: st_d.out_div   = clamp_div(req.wdata);
				default:     st_d.rdata     = 32'h0;
			endcase
		end

		// Flag registered so the status pin comes straight from a flop
		st_d.temp = st_d.dur != 32'h0;

		if (req.rd)
		begin
			case (req.addr)
				OFF_CTRL:
					st_d.rdata = {27'h0, st_q.out_en, 1'b0, st_q.src, st_q.enable};
				OFF_SEC:     st_d.rdata = st_q.tm.sec;
				OFF_NS:      st_d.rdata = {2'h0, st_q.tm.ns};
				OFF_FRAC:    st_d.rdata = st_q.tm.frac;
				OFF_RATE:    st_d.rdata = st_q.rate;
				OFF_TRATE:   st_d.rdata = st_q.temp_rate;
				OFF_TDUR:    st_d.rdata = st_q.dur;
				OFF_REF_DIV: st_d.rdata = {24'h0, st_q.ref_div};
				OFF_OUT_DIV: st_d.rdata = {24'h0, st_q.out_div};
				OFF_STATUS:  st_d.rdata = {31'h0, temp_on};
				default:     st_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q         <= '0;
			st_q.enable  <= EN_RST;
			st_q.src     <= SRC_INTERNAL;
			st_q.out_en  <= OUT_EN_RST;
			st_q.ref_div <= REF_DIV_RST;
			st_q.out_div <= OUT_DIV_RST;
		end
		else if (ce)
			st_q <= st_d;
	end

	// ==========================================================
	// Clock output
	sync_clock_out #(
		.MAX_EDGES (4)
	) u_clk_out (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.out_en  (st_q.out_en),
		.tick    (tick_eff),
		.inc     (inc),
		.divisor (st_q.out_div),
		.clk_o   (sync_clk_out)
	);

	assign rdata       = st_q.rdata;
	assign time_now    = st_q.tm;
	assign temp_active = st_q.temp;

	// ==========================================================
	// Checks
	logic [63:0] tot_ns;
	logic        sw_touch;

	assign tot_ns   = 64'(st_q.tm.sec) * 64'(NS_PER_SEC) + 64'(st_q.tm.ns);
	assign sw_touch = wr && (addr == OFF_CTRL || addr == OFF_STEP);

	a_ns_range: assert property (@(posedge sys_clk) disable iff (rst)
		st_q.tm.ns < NS_PER_SEC)
		else $error("nanoseconds out of range");

	a_load_time: assert property (@(posedge sys_clk) disable iff (rst)
		ce && wr && addr == OFF_CTRL && wdata[CTRL_LOAD]
		|=> st_q.tm.sec == $past(st_q.sec_stage) && st_q.tm.ns == $past(st_q.ns_stage)
			&& st_q.tm.frac == 32'h0)
		else $error("time load not applied");

	a_step_add: assert property (@(posedge sys_clk) disable iff (rst)
		ce && wr && addr == OFF_STEP && !tick_eff && st_q.tm.sec > 32'h2
			&& st_q.tm.sec < 32'hFFFFFFFD
		|=> tot_ns == $past(tot_ns) + 64'($signed($past(wdata))))
		else $error("step not added");

	a_sec_carry: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !sw_touch && tick_eff |=> st_q.tm.sec == $past(st_q.tm.sec)
			|| st_q.tm.sec == $past(st_q.tm.sec) + 32'h1)
		else $error("seconds carry wrong");

	a_temp_rate_used: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !wr && tick_eff && temp_on && scale == 8'h01 && st_q.tm.ns < 30'h3B9AC000
		|=> {st_q.tm.ns, st_q.tm.frac} == {$past(st_q.tm.ns), $past(st_q.tm.frac)}
			+ 62'(NOMINAL_INC + INC_W'($past(st_q.temp_rate))))
		else $error("temporary rate not used");

	a_dur_countdown: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !wr && tick_eff && st_q.dur > 32'(scale)
		|=> st_q.dur == $past(st_q.dur) - 32'($past(scale)))
		else $error("temporary duration not counted");

	a_temp_revert: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !wr && st_q.dur != 32'h0 && st_q.dur <= 32'(scale) && tick_eff
		|=> st_q.dur == 32'h0 ##0 act_rate == st_q.rate)
		else $error("temporary rate did not expire");

	a_out_div_range: assert property (@(posedge sys_clk) disable iff (rst)
		st_q.out_div >= DIV_MIN)
		else $error("output divisor below minimum");

	a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
		ce && rd && addr > OFF_STATUS |=> rdata == 32'h0)
		else $error("unmapped read not zero");

	a_frozen_ce: assert property (@(posedge sys_clk) disable iff (rst)
		!ce |=> $stable(st_q))
		else $error("state moved while disabled");

	// Read data stand for one cycle only
	a_rdata_clear: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !rd |=> rdata == 32'h0)
		else $error("read data held too long");

endmodule

`default_nettype wire

// [dv/testbench.sv]
/*
 * Self-checking bench for ptp_time_clock: registers, load, step,
 * rollover, rates, temporary rate, reference sources, clock output.
 * Assumes the package and design sources are compiled before it.
 */
`default_nettype none

module testbench import ptp_clock_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================
	// Signals and tables
	typedef struct {logic w; logic [5:0] a; logic [31:0] d; logic [31:0] e;} reg_row_t;
	typedef struct {logic [31:0] s; logic [29:0] n; logic [31:0] st;
		logic [31:0] es; logic [29:0] en;} step_row_t;

	logic              sys_clk = 1'h0;
	logic              rst = 1'h1;
	logic              ce = 1'h1;
	logic [ADDR_W-1:0] addr = 6'h00;
	logic [31:0]       wdata = 32'h0;
	logic              wr = 1'h0;
	logic              rd = 1'h0;
	logic              ext_ref = 1'h0;
	logic              ext_run = 1'h0;
	logic              prev_out = 1'h0;
	logic [31:0]       rdata;
	ptp_time_t         time_now;
	ptp_time_t         t0;
	logic              temp_active;
	logic              sync_clk_out;
	int                fail_count = 0;
	int                comparisons = 0;
	int                cyc = 0;
	int                c0 = 0;
	int                rises = 0;
	int                r0;

	reg_row_t regs [14] = '{
		'{1'h0, OFF_CTRL, 32'h0, 32'h1}, '{1'h0, OFF_REF_DIV, 32'h0, 32'h2},
		'{1'h0, OFF_OUT_DIV, 32'h0, 32'hA}, '{1'h0, OFF_TDUR, 32'h0, 32'h0},
		'{1'h0, OFF_STATUS, 32'h0, 32'h0}, '{1'h1, OFF_REF_DIV, 32'h1, 32'h2},
		'{1'h1, OFF_REF_DIV, 32'h1FF, 32'hFF}, '{1'h1, OFF_OUT_DIV, 32'h80, 32'h80},
		'{1'h1, OFF_RATE, 32'h12345678, 32'h12345678},
		'{1'h1, OFF_TRATE, 32'hC0000000, 32'hC0000000},
		'{1'h1, OFF_STEP, 32'h5, 32'h0}, '{1'h1, 6'h2C, 32'hFFFF, 32'h0},
		'{1'h1, OFF_CTRL, 32'h7, 32'h1}, '{1'h1, OFF_CTRL, 32'h19, 32'h11}};
	// Steps borrow and carry across seconds; below zero or past the top second they wrap
	step_row_t steps [4] = '{
		'{32'h5, 30'hA, 32'hFFFFFFEC, 32'h4, 30'h3B9AC9F6},
		'{32'h0, 30'h5, 32'hFFFFFFF6, 32'hFFFFFFFF, 30'h3B9AC9FB},
		'{32'h3, 30'h3B9AC9F6, 32'h19, 32'h4, 30'hF},
		'{32'hFFFFFFFF, NS_MAX, 32'h1, 32'h0, 30'h0}};
	logic [31:0] rates [3] = '{32'h40000000, 32'hC0000000, 32'h0};

	always #25 sys_clk = ~sys_clk;

	// External reference toggles every second cycle: one rise per 4 cycles
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		prev_out <= sync_clk_out;
		if (sync_clk_out === 1'h1 && prev_out === 1'h0)
			rises <= rises + 1;
		if (ext_run && cyc % 2 == 0)
			ext_ref <= ~ext_ref;
	end

	ptp_time_clock ptp_time_clock_i (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.ce           (ce),
		.addr         (addr),
		.wdata        (wdata),
		.wr           (wr),
		.rd           (rd),
		.rdata        (rdata),
		.ext_ref      (ext_ref),
		.time_now     (time_now),
		.temp_active  (temp_active),
		.sync_clk_out (sync_clk_out)
	);

	// ==========================================
	// Tasks
	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic chk_time(input ptp_time_t got, input ptp_time_t exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: time got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge sys_clk);
		wr <= 1'h0;
	endtask

	task automatic rd_reg(input logic [5:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge sys_clk);
		rd <= 1'h0;
		#1 chk_val(rdata, e, "read");
	endtask

	task automatic load(input logic [31:0] s, input logic [29:0] n, input logic [31:0] ctl);
		wr_reg(OFF_CTRL, 32'h0);
		wait_cyc(3);
		wr_reg(OFF_SEC, s);
		wr_reg(OFF_NS, n);
		wr_reg(OFF_CTRL, ctl | 32'h8);
		#1 chk_time(time_now, {s, n, 32'h0});
	endtask

	task automatic mark;
		#1;
		t0 = time_now;
		c0 = cyc;
	endtask

	// Compares elapsed fixed-point time against cycles times increment
	task automatic delta_chk(input int n, input logic [63:0] inc, input logic [63:0] extra);
		wait_cyc(n);
		#1 chk_val({2'h0, time_now.ns, time_now.frac} - {2'h0, t0.ns, t0.frac},
			64'(cyc - c0) * inc + extra, "elapsed");
	endtask

	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================
	// Sequence
	initial
	begin
		wait_cyc(5);
		rst <= 1'h0;
		foreach (regs[i])
		begin
			if (regs[i].w)
				wr_reg(regs[i].a, regs[i].d);
			rd_reg(regs[i].a, regs[i].e);
		end
		// Mid-run reset restores defaults left dirty by the table
		@(posedge sys_clk);
		rst <= 1'h1;
		#1 chk_time(time_now, '0);
		wait_cyc(5);
		rst <= 1'h0;
		rd_reg(OFF_RATE, 32'h0);
		rd_reg(OFF_OUT_DIV, 32'hA);
		foreach (steps[i])
		begin
			load(steps[i].s, steps[i].n, 32'h0);
			wr_reg(OFF_STEP, steps[i].st);
			#1 chk_time(time_now, {steps[i].es, steps[i].en, 32'h0});
		end
		load(32'hFFFFFFFF, 30'h3B9AC9F8, 32'h1);
		repeat (10)
		begin
			@(posedge sys_clk);
			#1;
			if (time_now.ns !== 30'h3B9AC9F8)
				break;
		end
		chk_time(time_now, '0);
		foreach (rates[i])
		begin
			wr_reg(OFF_RATE, rates[i]);
			wait_cyc(2);
			mark;
			delta_chk(8, 64'(NOMINAL_INC) + {{32{rates[i][31]}}, rates[i]}, 64'h0);
		end
		wr_reg(OFF_TRATE, 32'h40000000);
		wait_cyc(2);
		mark;
		wr_reg(OFF_TDUR, 32'h8);
		#1 chk_val(temp_active, 64'h1, "temp active");
		rd_reg(OFF_STATUS, 32'h1);
		delta_chk(20, 64'(NOMINAL_INC), 64'h8 * 64'h40000000);
		chk_val(temp_active, 64'h0, "temp expired");
		wr_reg(OFF_REF_DIV, 32'h4);
		wr_reg(OFF_CTRL, 32'h3);
		wait_cyc(8);
		mark;
		delta_chk(16, 64'(NOMINAL_INC), 64'h0);
		wr_reg(OFF_CTRL, 32'h5);
		ext_run <= 1'h1;
		wait_cyc(8);
		mark;
		delta_chk(16, 64'(NOMINAL_INC) >> 2, 64'h0);
		wr_reg(OFF_CTRL, 32'h1);
		r0 = rises;
		wait_cyc(100);
		chk_val(rises - r0, 64'h0, "output off");
		// Slowest divisor keeps the output far below the tick rate, no aliasing
		wr_reg(OFF_OUT_DIV, 32'hFF);
		wr_reg(OFF_CTRL, 32'h11);
		wait_cyc(600);
		r0 = rises;
		wait_cyc(8160);
		chk_val((rises - r0 >= 63 && rises - r0 <= 65), 64'h1, "nominal edges");
		wr_reg(OFF_RATE, 32'h7FFFFFFF);
		wait_cyc(600);
		r0 = rises;
		wait_cyc(8160);
		chk_val((rises - r0 >= 67 && rises - r0 <= 69), 64'h1, "rated edges");
		// Clock enable low freezes time and ignores strobes
		@(posedge sys_clk);
		ce <= 1'h0;
		wr_reg(OFF_RATE, 32'h0);
		mark;
		wait_cyc(20);
		#1 chk_time(time_now, t0);
		@(posedge sys_clk);
		ce <= 1'h1;
		rd_reg(OFF_RATE, 32'h7FFFFFFF);
		summarize;
	end

	initial
	begin
		wait_cyc(30000);
		fail_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		summarize;
	end

endmodule

`default_nettype wire
